// *** cap_pkg.sv ***
package cap_pkg;

    // device control register: index on the device's own register port
    localparam logic [3:0] CTRL_INDEX = 4'hF;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] CTRL_WRITABLE = 16'hF800;

    // control field positions
    localparam int DEPTH_LSB = 14;
    localparam int STOP_BIT = 13;
    localparam int DUAL_BIT = 12;
    localparam int PATTERN_BIT = 11;

    // read-only status bits in the same register
    localparam int STAT_FULL_BIT = 1;
    localparam int STAT_EMPTY_BIT = 0;

    // buffer geometry
    localparam int MEM_BITS = 12;
    localparam int MAX_DEPTH = 4096;
    localparam int BASE_DEPTH = 512;

    // read clock edges from readout start to first output word
    localparam int READ_LATENCY = 3;

    // pattern bytes, entry 0 in the low byte
    localparam logic [63:0] PATTERN_SEQ = 64'hFBFCFDFE04030201;

    // controller register map (byte offsets on the plain port)
    localparam logic [3:0] HOST_CTRL = 4'h0;
    localparam logic [3:0] HOST_STATUS = 4'h4;
    localparam logic [3:0] HOST_CFG = 4'h8;
    localparam logic [3:0] HOST_DATA = 4'hC;

    // controller control bits
    localparam int GO_CAPTURE_BIT = 0;
    localparam int GO_READ_BIT = 1;
    localparam int BUF_RESET_BIT = 2;
    localparam int CFG_FETCH_BIT = 3;
    localparam logic [31:0] HOST_CTRL_RESET = 32'h0000_0000;

    // read clock made by the controller
    localparam int CLK_PERIOD_NS = 5;
    localparam int RCLK_PERIOD_NS = 50;
    localparam int RCLK_HALF = RCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);

    // buffer states
    typedef enum logic [1:0] {
        ST_EMPTY = 2'b00,
        ST_CAPTURE = 2'b01,
        ST_READ = 2'b10,
        ST_FROZEN = 2'b11
    } buf_state_t;

endpackage

// *** cap_link_if.sv ***
interface cap_link_if;

    // gates and clock from the reader
    logic capture_gate;
    logic readout_gate;
    logic buf_reset;
    logic read_clk;

    // register port of the device
    logic [3:0] cfg_addr;
    logic [15:0] cfg_wdata;
    logic cfg_wr;
    logic cfg_rd;
    logic [15:0] cfg_rdata;

    // data, strobe and flags from the device
    logic [7:0] first_output_port;
    logic [7:0] second_output_port;
    logic second_port_oe;
    logic output_strobe;
    logic out_of_range;
    logic buffer_full_flag;
    logic buffer_empty_flag;
    logic capture_gate_synced;

    modport dev (
        input capture_gate, readout_gate, buf_reset, read_clk,
        input cfg_addr, cfg_wdata, cfg_wr, cfg_rd,
        output cfg_rdata,
        output first_output_port, second_output_port, second_port_oe,
        output output_strobe, out_of_range,
        output buffer_full_flag, buffer_empty_flag, capture_gate_synced
    );

    modport host (
        output capture_gate, readout_gate, buf_reset, read_clk,
        output cfg_addr, cfg_wdata, cfg_wr, cfg_rd,
        input cfg_rdata,
        input first_output_port, second_output_port, second_port_oe,
        input output_strobe, out_of_range,
        input buffer_full_flag, buffer_empty_flag, capture_gate_synced
    );

endinterface

// *** capture_buffer_dev.sv ***
// Summary of operation
// RULE1 - dual bit clear: pattern on first port only
// RULE2 - pattern select replaces converter on all outputs
// RULE3 - pattern mode: range flag high until empty
// RULE4 - single port pattern 01..04,FE..FB, second Hi-Z
// RULE5 - dual pattern: second odd, first even bytes
// RULE6 - every output word comes with strobe transition
// RULE7 - depth field selects 512/1024/2048/4096 bytes
// RULE8 - readout starts only after buffer full
// RULE9 - never capture and read together
// RULE10 - empty after last byte, no reread
// RULE11 - capture only from empty; capture clears empty
// RULE12 - synchronised readout gate clears full flag
// RULE13 - buffer reset: full clear, empty set, abort
// RULE14 - store samples each clock while gate active
// RULE15 - wrap and overwrite, or stop when full
// RULE16 - reader supplies free read clock and gate
// RULE17 - dual bit picks one or two readout ports
// RULE18 - two port readout: second port first
// RULE19 - capture during readout freezes until reset
// RULE20 - first data on third read clock edge
// RULE21 - output sample-clock copy of capture gate
// RULE22 - range flag sticky until readout empties
// RULE23 - gate and clock crossings use two flops
// RULE24 - pattern restarts at each readout start
module capture_buffer_dev
    import cap_pkg::*;
(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // converted samples
    input wire logic [7:0] i_sample,
    input wire logic i_sample_over,
    // link to the reader
    cap_link_if.dev link
);

    logic [7:0] mem [MAX_DEPTH];

    // synchroniser stages: gate, readout, reset, read clock
    logic [3:0] sync1_reg;
    logic [3:0] sync2_reg;
    logic rclk_prev_reg;
    logic gate_s;
    logic ren_s;
    logic rst_s;
    logic rclk_rise;

    // buffer state
    buf_state_t state_reg, state_next;
    logic [MEM_BITS-1:0] wptr_reg, wptr_next;
    logic [MEM_BITS-1:0] rptr_reg, rptr_next;
    logic [MEM_BITS:0] count_reg, count_next;
    logic [MEM_BITS:0] left_reg, left_next;
    logic [1:0] prime_reg, prime_next;
    logic [2:0] pat_reg, pat_next;
    logic full_reg, full_next;
    logic empty_reg, empty_next;
    logic or_reg, or_next;
    logic [7:0] p1_reg, p1_next;
    logic [7:0] p2_reg, p2_next;
    logic strobe_reg, strobe_next;
    logic oe_reg, oe_next;
    logic wsync_reg;
    logic mem_we;

    // configuration register
    logic [15:0] ctrl_reg, ctrl_next;
    logic [15:0] rdata_reg, rdata_next;

    // derived configuration
    logic [MEM_BITS:0] depth;
    logic [MEM_BITS-1:0] mask;
    logic stop_on_full;
    logic dual;
    logic pattern_on;

    // two flop crossing of the reader's pins
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sync1_reg <= 4'h0;
            sync2_reg <= 4'h0;
            rclk_prev_reg <= 1'b0;
            wsync_reg <= 1'b0;
        end else begin
            sync1_reg <= {link.read_clk, link.buf_reset,
                          link.readout_gate, link.capture_gate}; // see RULE23
            sync2_reg <= sync1_reg;
            rclk_prev_reg <= sync2_reg[3];
            wsync_reg <= sync2_reg[0]; // see RULE21
        end
    end

    assign gate_s = sync2_reg[0];
    assign ren_s = sync2_reg[1];
    assign rst_s = sync2_reg[2];
    assign rclk_rise = sync2_reg[3] & ~rclk_prev_reg; // see RULE16

    // configuration decode
    assign depth = (MEM_BITS+1)'(BASE_DEPTH) << ctrl_reg[DEPTH_LSB +: 2]; // see RULE7
    assign mask = MEM_BITS'(depth - 1'b1);
    assign stop_on_full = ctrl_reg[STOP_BIT];
    assign dual = ctrl_reg[DUAL_BIT];
    assign pattern_on = ctrl_reg[PATTERN_BIT];

    // byte k of the next output group: pattern or buffer
    function automatic logic [7:0] pick(input logic [1:0] k);
        logic [2:0] pi;
        logic [MEM_BITS-1:0] ai;
        pi = 3'(pat_reg + 3'(k));
        ai = MEM_BITS'(rptr_reg + MEM_BITS'(k)) & mask;
        if (pattern_on) begin
            pick = PATTERN_SEQ[{pi, 3'b000} +: 8]; // see RULE2
        end else begin
            pick = mem[ai];
        end
    endfunction

    // register port next values
    always_comb begin
        ctrl_next = ctrl_reg;
        rdata_next = 16'h0000;
        if (link.cfg_wr && link.cfg_addr == CTRL_INDEX) begin
            ctrl_next = link.cfg_wdata & CTRL_WRITABLE;
        end
        if (link.cfg_rd && link.cfg_addr == CTRL_INDEX) begin
            rdata_next = ctrl_reg;
            rdata_next[STAT_FULL_BIT] = full_reg;
            rdata_next[STAT_EMPTY_BIT] = empty_reg;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl_reg <= CTRL_RESET;
            rdata_reg <= 16'h0000;
        end else begin
            ctrl_reg <= ctrl_next;
            rdata_reg <= rdata_next;
        end
    end

    // buffer control next values
    always_comb begin
        state_next = state_reg;
        wptr_next = wptr_reg;
        rptr_next = rptr_reg;
        count_next = count_reg;
        left_next = left_reg;
        prime_next = prime_reg;
        pat_next = pat_reg;
        full_next = full_reg;
        empty_next = empty_reg;
        or_next = or_reg;
        p1_next = p1_reg;
        p2_next = p2_reg;
        strobe_next = strobe_reg;
        oe_next = oe_reg;
        mem_we = 1'b0;
        if (rst_s) begin
            state_next = ST_EMPTY; // see RULE13
            full_next = 1'b0;
            empty_next = 1'b1;
            or_next = 1'b0;
            oe_next = 1'b0;
        end else begin
            case (state_reg)
                ST_EMPTY: begin
                    if (gate_s) begin
                        state_next = ST_CAPTURE; // see RULE11
                        empty_next = 1'b0;
                        wptr_next = '0;
                        count_next = '0;
                    end
                end
                ST_CAPTURE: begin
                    if (gate_s && ren_s) begin
                        state_next = ST_FROZEN; // see RULE19
                    end else if (gate_s) begin
                        if (!(stop_on_full && full_reg)) begin // see RULE15
                            mem_we = 1'b1; // see RULE14
                            wptr_next = MEM_BITS'(wptr_reg + 1'b1) & mask;
                            if (i_sample_over) begin
                                or_next = 1'b1; // see RULE22
                            end
                            if (count_reg != depth) begin
                                count_next = count_reg + 1'b1;
                            end
                            if (count_reg == depth - 1'b1) begin
                                full_next = 1'b1;
                            end
                        end
                    end else if (ren_s && full_reg) begin // see RULE8
                        state_next = ST_READ;
                        full_next = 1'b0; // see RULE12
                        rptr_next = wptr_reg;
                        left_next = depth;
                        prime_next = 2'd0;
                        pat_next = 3'd0; // see RULE24
                        oe_next = dual; // see RULE1
                        if (pattern_on) begin
                            or_next = 1'b1; // see RULE3
                        end
                    end
                end
                ST_READ: begin
                    if (gate_s) begin
                        state_next = ST_FROZEN; // see RULE19
                    end else if (rclk_rise && ren_s) begin
                        if (prime_reg != 2'(READ_LATENCY - 1)) begin
                            prime_next = prime_reg + 1'b1; // see RULE20
                        end else begin
                            strobe_next = ~strobe_reg; // see RULE6
                            if (dual) begin
                                p2_next = pick(2'd0); // see RULE18
                                p1_next = pick(2'd1); // see RULE5
                                rptr_next = MEM_BITS'(rptr_reg + 2'd2) & mask;
                                pat_next = 3'(pat_reg + 3'd2);
                                left_next = left_reg - 2'd2;
                            end else begin
                                p1_next = pick(2'd0); // see RULE4
                                rptr_next = MEM_BITS'(rptr_reg + 1'b1) & mask;
                                pat_next = 3'(pat_reg + 3'd1);
                                left_next = left_reg - 1'b1; // see RULE17
                            end
                            if (left_next == '0) begin
                                state_next = ST_EMPTY; // see RULE10
                                empty_next = 1'b1;
                                or_next = 1'b0; // see RULE22
                            end
                        end
                    end
                end
                ST_FROZEN: begin
                    state_next = ST_FROZEN; // see RULE9
                end
                default: begin
                    state_next = ST_EMPTY;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg <= ST_EMPTY;
            wptr_reg <= '0;
            rptr_reg <= '0;
            count_reg <= '0;
            left_reg <= '0;
            prime_reg <= 2'd0;
            pat_reg <= 3'd0;
            full_reg <= 1'b0;
            empty_reg <= 1'b1;
            or_reg <= 1'b0;
            p1_reg <= 8'h00;
            p2_reg <= 8'h00;
            strobe_reg <= 1'b0;
            oe_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            wptr_reg <= wptr_next;
            rptr_reg <= rptr_next;
            count_reg <= count_next;
            left_reg <= left_next;
            prime_reg <= prime_next;
            pat_reg <= pat_next;
            full_reg <= full_next;
            empty_reg <= empty_next;
            or_reg <= or_next;
            p1_reg <= p1_next;
            p2_reg <= p2_next;
            strobe_reg <= strobe_next;
            oe_reg <= oe_next;
        end
    end

    // sample storage, no reset on the array
    always_ff @(posedge i_clk_sys) begin
        if (mem_we) begin
            mem[wptr_reg] <= i_sample;
        end
    end

    // outputs to the reader
    assign link.cfg_rdata = rdata_reg;
    assign link.first_output_port = p1_reg;
    assign link.second_output_port = p2_reg;
    assign link.second_port_oe = oe_reg;
    assign link.output_strobe = strobe_reg;
    assign link.out_of_range = or_reg;
    assign link.buffer_full_flag = full_reg;
    assign link.buffer_empty_flag = empty_reg;
    assign link.capture_gate_synced = wsync_reg;

endmodule // capture_buffer_dev

// *** capture_reader_host.sv ***
module capture_reader_host
    import cap_pkg::*;
(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // software register port
    input wire logic [3:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // link to the device
    cap_link_if.host link
);

    // synchronisers: full, empty, strobe, synced gate, range
    logic [4:0] sync1_reg;
    logic [4:0] sync2_reg;
    logic strobe_prev_reg;
    logic full_s;
    logic empty_s;
    logic strobe_edge;

    logic [31:0] ctrl_reg, ctrl_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [3:0] div_reg, div_next;
    logic rclk_reg, rclk_next;
    logic gate_reg, gate_next;
    logic ren_reg, ren_next;
    logic cfg_wr_reg, cfg_wr_next;
    logic cfg_rd_reg, cfg_rd_next;
    logic cfg_dly_reg, cfg_dly_next;
    logic [15:0] cfg_wdata_reg, cfg_wdata_next;
    logic [15:0] cfg_back_reg, cfg_back_next;
    logic [15:0] data_reg, data_next;
    logic [12:0] words_reg, words_next;

    // device pins cross by two flops
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sync1_reg <= 5'h00;
            sync2_reg <= 5'h00;
            strobe_prev_reg <= 1'b0;
        end else begin
            sync1_reg <= {link.out_of_range, link.capture_gate_synced,
                          link.output_strobe, link.buffer_empty_flag,
                          link.buffer_full_flag};
            sync2_reg <= sync1_reg;
            strobe_prev_reg <= sync2_reg[2];
        end
    end

    assign full_s = sync2_reg[0];
    assign empty_s = sync2_reg[1];
    assign strobe_edge = sync2_reg[2] ^ strobe_prev_reg;

    // controller next values
    always_comb begin
        ctrl_next = ctrl_reg;
        rdata_next = 32'h0000_0000;
        cfg_wr_next = 1'b0;
        cfg_rd_next = 1'b0;
        cfg_wdata_next = cfg_wdata_reg;
        cfg_back_next = cfg_back_reg;
        data_next = data_reg;
        words_next = words_reg;
        cfg_dly_next = cfg_rd_reg;
        // free running read clock by divider
        div_next = div_reg + 1'b1;
        rclk_next = rclk_reg;
        if (div_reg == 4'(RCLK_HALF - 1)) begin
            div_next = 4'h0;
            rclk_next = ~rclk_reg; // see RULE16
        end
        if (i_wr && i_addr == HOST_CTRL) begin
            ctrl_next = i_wdata;
            cfg_rd_next = i_wdata[CFG_FETCH_BIT];
        end
        if (i_wr && i_addr == HOST_CFG) begin
            cfg_wr_next = 1'b1;
            cfg_wdata_next = i_wdata[15:0];
        end
        if (cfg_dly_reg) begin
            cfg_back_next = link.cfg_rdata;
        end
        // capture only from empty, dropped once full
        gate_next = ctrl_reg[GO_CAPTURE_BIT] && !ren_reg
                    && !ctrl_reg[BUF_RESET_BIT]
                    && (gate_reg ? !full_s : empty_s); // see RULE11
        // readout only once full, never beside the capture gate
        ren_next = ctrl_reg[GO_READ_BIT] && !gate_reg && !sync2_reg[3]
                   && !ctrl_reg[BUF_RESET_BIT]
                   && (ren_reg ? !empty_s : full_s); // see RULE8
        if (ren_next && !ren_reg) begin
            words_next = 13'h0000;
        end
        if (strobe_edge) begin
            data_next = {link.second_output_port, link.first_output_port};
            words_next = words_reg + 1'b1;
        end
        if (i_rd) begin
            case (i_addr)
                HOST_CTRL: rdata_next = ctrl_reg;
                HOST_STATUS: rdata_next = {26'h0, ren_reg, gate_reg,
                                           sync2_reg[4], sync2_reg[3],
                                           sync2_reg[1:0]};
                HOST_CFG: rdata_next = {16'h0000, cfg_back_reg};
                HOST_DATA: rdata_next = {3'h0, words_reg, data_reg};
                default: rdata_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl_reg <= HOST_CTRL_RESET;
            rdata_reg <= 32'h0000_0000;
            div_reg <= 4'h0;
            rclk_reg <= 1'b0;
            gate_reg <= 1'b0;
            ren_reg <= 1'b0;
            cfg_wr_reg <= 1'b0;
            cfg_rd_reg <= 1'b0;
            cfg_dly_reg <= 1'b0;
            cfg_wdata_reg <= 16'h0000;
            cfg_back_reg <= 16'h0000;
            data_reg <= 16'h0000;
            words_reg <= 13'h0000;
        end else begin
            ctrl_reg <= ctrl_next;
            rdata_reg <= rdata_next;
            div_reg <= div_next;
            rclk_reg <= rclk_next;
            gate_reg <= gate_next;
            ren_reg <= ren_next; // see RULE9
            cfg_wr_reg <= cfg_wr_next;
            cfg_rd_reg <= cfg_rd_next;
            cfg_dly_reg <= cfg_dly_next;
            cfg_wdata_reg <= cfg_wdata_next;
            cfg_back_reg <= cfg_back_next;
            data_reg <= data_next;
            words_reg <= words_next;
        end
    end

    // pins toward the device
    assign link.capture_gate = gate_reg;
    assign link.readout_gate = ren_reg;
    assign link.buf_reset = ctrl_reg[BUF_RESET_BIT];
    assign link.read_clk = rclk_reg;
    assign link.cfg_addr = CTRL_INDEX;
    assign link.cfg_wdata = cfg_wdata_reg;
    assign link.cfg_wr = cfg_wr_reg;
    assign link.cfg_rd = cfg_rd_reg;
    assign o_rdata = rdata_reg;

endmodule // capture_reader_host

// *** cap_link_chk.sv ***
module cap_link_chk (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // link signals watched
    input wire logic capture_gate,
    input wire logic readout_gate,
    input wire logic buf_reset,
    input wire logic output_strobe,
    input wire logic out_of_range,
    input wire logic buffer_full_flag,
    input wire logic buffer_empty_flag,
    input wire logic capture_gate_synced
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);

    // flag and gate relations
    flags_excl_a: assert property (
        !(buffer_full_flag && buffer_empty_flag))
        else $error("full and empty flags together");
    range_clear_a: assert property (
        $rose(buffer_empty_flag) |-> !out_of_range)
        else $error("range flag kept after empty");
    read_after_full_a: assert property (
        $changed(output_strobe) |->
            !buffer_full_flag && !$past(buffer_empty_flag))
        else $error("word out while full or empty");
    no_overlap_a: assert property (
        $changed(output_strobe) |-> !capture_gate_synced)
        else $error("word out during capture");
    gate_sync_a: assert property (
        $rose(capture_gate) |-> ##[2:4] capture_gate_synced)
        else $error("capture gate copy late");
    empty_clear_a: assert property (
        $rose(capture_gate_synced) |-> ##[0:1] !buffer_empty_flag)
        else $error("empty flag not cleared by capture");
    full_clear_a: assert property (
        $rose(readout_gate) |-> ##[1:5] !buffer_full_flag)
        else $error("full flag not cleared by readout");
    reset_flags_a: assert property (
        $rose(buf_reset) |-> ##[2:3] buffer_empty_flag && !buffer_full_flag)
        else $error("buffer reset left flags wrong");
    first_word_a: assert property (
        $rose(readout_gate) |-> ##1 $stable(output_strobe) [*8])
        else $error("first word too early");
endmodule // cap_link_chk

// *** test_adc_capture_buffer_readout.sv ***
module test_adc_capture_buffer_readout;
    timeunit 1ns;
    timeprecision 1ps;
    import cap_pkg::*;

    logic i_clk_sys, i_rst_n, i_sample_over, i_wr, i_rd;
    logic [7:0] i_sample;
    logic [3:0] i_addr;
    logic [31:0] i_wdata, o_rdata, d;
    int n_fail, checked;
    logic [15:0] cfgs [5] = '{16'h0800, 16'h5800, 16'h0000, 16'hB000,
        16'hE000};

    cap_link_if link ();
    // second port as seen on the board: floats while not driven
    wire [7:0] pin2 = link.second_port_oe ? link.second_output_port : 8'hZZ;
    capture_buffer_dev capture_buffer_dev_i (.i_clk_sys, .i_rst_n,
        .i_sample, .i_sample_over, .link(link));
    capture_reader_host capture_reader_host_i (.i_clk_sys, .i_rst_n,
        .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .link(link));
    cap_link_chk cap_link_chk_i (.i_clk_sys, .i_rst_n,
        .capture_gate(link.capture_gate), .readout_gate(link.readout_gate),
        .buf_reset(link.buf_reset), .output_strobe(link.output_strobe),
        .out_of_range(link.out_of_range),
        .buffer_full_flag(link.buffer_full_flag),
        .buffer_empty_flag(link.buffer_empty_flag),
        .capture_gate_synced(link.capture_gate_synced));

    // clock and counting sample source
    initial begin
        i_clk_sys = 1'b0;
        forever #2.5 i_clk_sys = ~i_clk_sys;
    end
    always @(posedge i_clk_sys) i_sample <= i_sample + 8'h01;

    task test_done;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one cycle strobes on the plain register port
    task wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge i_clk_sys);
        i_addr <= a;
        i_wdata <= v;
        i_wr <= 1'b1;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
    endtask
    task rd(input logic [3:0] a);
        @(posedge i_clk_sys);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask

    function automatic logic [7:0] pat(input int k);
        return PATTERN_SEQ[8*(k%8) +: 8];
    endfunction

    // capture, then read the whole buffer (or abort after five words)
    task run(input logic [15:0] cfg, input bit abort);
        int n, w, t;
        logic s;
        logic [7:0] prev;
        bit dual;
        dual = cfg[DUAL_BIT];
        n = (BASE_DEPTH << cfg[15:14]) >> dual;
        wr(HOST_CFG, {16'h0000, cfg});
        wr(HOST_CTRL, 32'h0000_0008);
        repeat (6) @(posedge i_clk_sys);
        rd(HOST_CFG);
        chk(d[15:8] & 8'hF8, cfg[15:8]);
        wr(HOST_CTRL, 32'h0000_0001);
        repeat ($urandom_range(8, 300)) @(posedge i_clk_sys);
        i_sample_over <= 1'b1;
        @(posedge i_clk_sys);
        i_sample_over <= 1'b0;
        for (t = 0; link.buffer_full_flag !== 1'b1 && t < 9000; t++) begin
            @(posedge i_clk_sys);
            #1;
        end
        chk(link.buffer_full_flag, 8'h01);
        chk(link.out_of_range, 8'h01);
        s = link.output_strobe;
        wr(HOST_CTRL, 32'h0000_0002);
        w = 0;
        for (t = 0; w < n && t < 50 * n; t++) begin
            @(posedge i_clk_sys);
            #1;
            if (link.output_strobe !== s) begin
                s = link.output_strobe;
                if (cfg[PATTERN_BIT]) begin
                    chk(link.first_output_port, pat(dual ? 2*w+1 : w));
                    chk(pin2, dual ? pat(2*w) : 8'hZZ);
                    chk(link.out_of_range, 8'(w < n - 1));
                end else begin
                    if (dual && w > 0)
                        chk(pin2, prev + 8'h01);
                    if (dual)
                        prev = pin2;
                    if (dual || w > 0)
                        chk(link.first_output_port, prev + 8'h01);
                    prev = link.first_output_port;
                end
                w++;
                if (abort && w == 5)
                    n = 5;
            end
        end
        chk(8'(w == n), 8'h01);
        if (abort) begin
            wr(HOST_CTRL, 32'h0000_0004);
            repeat (6) @(posedge i_clk_sys);
            wr(HOST_CTRL, 32'h0000_0000);
        end
        repeat (40) @(posedge i_clk_sys);
        chk(8'(link.output_strobe === s), 8'h01);
        rd(HOST_STATUS);
        chk(d[7:0], 8'h02);
    endtask

    // main sequence
    initial begin
        i_rst_n = 1'b0;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_addr = 4'h0;
        i_wdata = 32'h0000_0000;
        i_sample_over = 1'b0;
        n_fail = 0;
        checked = 0;
        i_sample = 8'($urandom(53269));
        repeat (4) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        rd(4'h2);
        chk(d[7:0], 8'h00);
        rd(HOST_STATUS);
        chk(d[7:0], 8'h02);
        foreach (cfgs[i])
            run(cfgs[i], i == 2);
        test_done;
    end

    // watchdog against a hang
    initial begin
        #450000;
        n_fail++;
        test_done;
    end
endmodule // test_adc_capture_buffer_readout
